// ### rtl/dps_params.svh
// constants of the dynamic phase shedding controller
//
// Behaviour
// - with shedding on and sense below threshold, drop to reduced phase count
// - sense rising above threshold restores full programmed phase count at once
// - thresholds are percentages of the full current limit sense level
// - each code picks rising/falling levels: 20/15, 25/20, 30/25, 35/30 percent
// - shedding off at reset; soft-start runs with all installed phases
// - shed enable accepted only after soft-start done and power good high
// - once enabled, sense is compared continuously against the selected threshold
// - voltage step transition or transient boost forces all phases back
// - after such a reset, shedding resumes only after a fixed delay
// - grounded phase three/four drives set two, three or four installed phases
// - average current reference is phase current sum over working phases
// - phase shed select 0 means one phase, 1 means two phases
// - the shed select strategy also sets the load based shedding phase count
// - shed enable sits at data stream position 8, default off
// - two-bit threshold code sits at data stream positions 4 to 5
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// register offsets
`define DPS_OFS_CTRL       8'h00
`define DPS_OFS_STATUS     8'h04
`define DPS_OFS_AVG        8'h08

// control word: data stream position p sits at bit (8 - p)
`define DPS_CTRL_EN_BIT    0
`define DPS_CTRL_PSEL_BIT  2
`define DPS_CTRL_THR_LO    3
`define DPS_CTRL_THR_HI    4
`define DPS_CTRL_RESET     8'h00

// status word layout
`define DPS_ST_ACT_LO      0
`define DPS_ST_INST_LO     4
`define DPS_ST_MODE_LO     8
`define DPS_ST_PG_BIT      12
`define DPS_ST_REFUSED_BIT 13

// threshold levels in percent of full load
`define DPS_PCT_RISE_0     6'd20
`define DPS_PCT_FALL_0     6'd15
`define DPS_PCT_STEP       6'd5

// full load reference in millivolts
`define DPS_FULL_LOAD_MV   1800

// re-arm delay after a shedding reset
`define DPS_CLK_PERIOD_NS  4
`define DPS_REARM_NS       10000
`define DPS_REARM_CYC      (`DPS_REARM_NS / `DPS_CLK_PERIOD_NS)

// cycles spent settling the straps after reset
`define DPS_STRAP_WAIT     2'd3

`endif

// ### rtl/dps_pkg.sv
// types of the dynamic phase shedding controller
package dps_pkg;

  typedef enum logic [1:0] {
    DPS_ALL,
    DPS_REARM,
    DPS_RUN,
    DPS_SHED
  } dps_mode_e;

  // synchronised pin group
  typedef struct packed {
    logic pg;
    logic gnd3;
    logic gnd4;
    logic below;
    logic above;
  } dps_pins_s;

  typedef struct packed {
    dps_mode_e   mode;
    logic [7:0]  ctrl;
    logic [2:0]  installed;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic [11:0] rearm_cnt;
    logic [2:0]  active;
    logic [3:0]  phase_en;
    logic [5:0]  rise_pct;
    logic [5:0]  fall_pct;
    logic [15:0] avg;
    logic        refused;
    logic [31:0] rdata;
  } dps_state_s;

endpackage

// ### rtl/dps_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module dps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dps_sync_s;

  dps_sync_s s_q;
  dps_sync_s s_d;

  // first stage feeds only the second
  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  // register the stages
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sync;

endmodule // dps_sync

// ### rtl/dps_core.sv
// dynamic phase shedding controller with register port
`timescale 1ns/1ps
`include "dps_params.svh"
module dps_core
  import dps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output      logic [31:0] bus_rdata,
  input  wire logic        power_good,
  input  wire logic        soft_start_done,
  input  wire logic        phase_three_grounded,
  input  wire logic        phase_four_grounded,
  input  wire logic        sense_below_fall,
  input  wire logic        sense_above_rise,
  input  wire logic        voltage_step_transition,
  input  wire logic        transient_boost_detect,
  input  wire logic [15:0] phase_current_sum,
  output      logic [1:0]  shed_threshold_code,
  output      logic [5:0]  thr_rise_pct,
  output      logic [5:0]  thr_fall_pct,
  output      logic [2:0]  active_phase_count,
  output      logic [3:0]  phase_enable,
  output      logic [15:0] avg_current_ref
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  localparam logic [11:0] REARM_LOAD = 12'(`DPS_REARM_CYC - 1);

  dps_state_s s_q;
  dps_state_s s_d;
  dps_pins_s  pins_raw;
  dps_pins_s  pins;

  logic       ctl_en;
  logic       ctl_psel;
  logic [1:0] ctl_code;
  logic [2:0] reduced;
  logic       shed_reset;
  logic       en_allowed;
  logic [7:0] wr_ctrl;
  logic       refuse_now;
  logic [2:0] inst_pin;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  // pins from outside the clock domain
  assign pins_raw.pg    = power_good;
  assign pins_raw.gnd3  = phase_three_grounded;
  assign pins_raw.gnd4  = phase_four_grounded;
  assign pins_raw.below = sense_below_fall;
  assign pins_raw.above = sense_above_rise;

  // comparators and straps pass two flops first
  dps_sync #(
    .W ($bits(dps_pins_s))
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (pins_raw),
    .q     (pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoded control fields

  // fields of the stored data stream
  assign ctl_en   = s_q.ctrl[`DPS_CTRL_EN_BIT];
  assign ctl_psel = s_q.ctrl[`DPS_CTRL_PSEL_BIT];
  assign ctl_code = s_q.ctrl[`DPS_CTRL_THR_HI:`DPS_CTRL_THR_LO];

  // reduced count from the shed strategy
  assign reduced = ctl_psel ? 3'd2 : 3'd1;

  // voltage steps and load transients cancel shedding
  assign shed_reset = voltage_step_transition | transient_boost_detect;

  // enable only once start-up has settled
  assign en_allowed = soft_start_done & pins.pg;

  // installed phases from grounded drive outputs
  always_comb begin
    if (pins.gnd3 && pins.gnd4) begin
      inst_pin = 3'd2;
    end else if (pins.gnd4) begin
      inst_pin = 3'd3;
    end else begin
      inst_pin = 3'd4;
    end
  end

  // control write with enable gating
  always_comb begin
    wr_ctrl    = bus_wdata[7:0];
    refuse_now = 1'b0;
    if (wr_ctrl[`DPS_CTRL_EN_BIT] && !en_allowed) begin
      wr_ctrl[`DPS_CTRL_EN_BIT] = 1'b0;
      refuse_now                = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;

    // strap capture after the synchroniser has filled
    if (!s_q.strap_done) begin
      if (s_q.strap_cnt == `DPS_STRAP_WAIT) begin
        s_d.installed  = inst_pin;
        s_d.strap_done = 1'b1;
      end else begin
        s_d.strap_cnt = s_q.strap_cnt + 2'd1;
      end
    end

    // register writes
    if (bus_wr && bus_addr == `DPS_OFS_CTRL) begin
      s_d.ctrl = wr_ctrl;
    end

    // refused enable flag, set wins over read clear
    if (bus_rd && bus_addr == `DPS_OFS_STATUS) begin
      s_d.refused = 1'b0;
    end
    if (bus_wr && bus_addr == `DPS_OFS_CTRL && refuse_now) begin
      s_d.refused = 1'b1;
    end

    // shedding sequence
    case (s_q.mode)
      DPS_ALL: begin
        // shedding off: every installed phase runs
        if (ctl_en && s_q.strap_done) begin
          s_d.mode = DPS_RUN;
        end
      end
      DPS_REARM: begin
        // hold all phases until the delay expires
        if (s_q.rearm_cnt == 12'd0) begin
          s_d.mode = DPS_RUN;
        end else begin
          s_d.rearm_cnt = s_q.rearm_cnt - 12'd1;
        end
      end
      DPS_RUN: begin
        // light load drops phases
        if (pins.below) begin
          s_d.mode = DPS_SHED;
        end
      end
      DPS_SHED: begin
        // load rise restores all phases at once
        if (pins.above) begin
          s_d.mode = DPS_RUN;
        end
      end
      default: begin
        s_d.mode = DPS_ALL;
      end
    endcase

    // overrides: disabled or shedding reset
    if (!ctl_en) begin
      s_d.mode = DPS_ALL;
    end else if (shed_reset && s_q.mode != DPS_ALL) begin
      s_d.mode      = DPS_REARM;
      s_d.rearm_cnt = REARM_LOAD;
    end

    // working phase count
    if (s_d.mode == DPS_SHED) begin
      s_d.active = reduced;
    end else if (s_d.strap_done) begin
      s_d.active = s_d.installed;
    end else begin
      s_d.active = 3'd2;
    end

    // per-phase enables from the count
    s_d.phase_en[0] = 1'b1;
    s_d.phase_en[1] = s_d.active >= 3'd2;
    s_d.phase_en[2] = s_d.active >= 3'd3;
    s_d.phase_en[3] = s_d.active >= 3'd4;

    // threshold pair in percent of full load
    s_d.rise_pct = `DPS_PCT_RISE_0 + 6'(`DPS_PCT_STEP * ctl_code);
    s_d.fall_pct = `DPS_PCT_FALL_0 + 6'(`DPS_PCT_STEP * ctl_code);

    // average current over working phases
    case (s_q.active)
      3'd1:    s_d.avg = phase_current_sum;
      3'd2:    s_d.avg = phase_current_sum >> 1;
      3'd3:    s_d.avg = phase_current_sum / 16'd3;
      3'd4:    s_d.avg = phase_current_sum >> 2;
      default: s_d.avg = phase_current_sum;
    endcase

    // read data for one cycle only
    s_d.rdata = 32'h0;
    if (bus_rd) begin
      case (bus_addr)
        `DPS_OFS_CTRL: begin
          s_d.rdata = {24'h0, s_q.ctrl};
        end
        `DPS_OFS_STATUS: begin
          s_d.rdata[`DPS_ST_ACT_LO +: 3]   = s_q.active;
          s_d.rdata[`DPS_ST_INST_LO +: 3]  = s_q.installed;
          s_d.rdata[`DPS_ST_MODE_LO +: 2]  = s_q.mode;
          s_d.rdata[`DPS_ST_PG_BIT]        = pins.pg;
          s_d.rdata[`DPS_ST_REFUSED_BIT]   = s_q.refused;
        end
        `DPS_OFS_AVG: begin
          s_d.rdata = {16'h0, s_q.avg};
        end
        default: begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q            <= '0;
      s_q.mode       <= DPS_ALL;
      s_q.ctrl       <= `DPS_CTRL_RESET;
      s_q.installed  <= 3'd2;
      s_q.active     <= 3'd2;
      s_q.phase_en   <= 4'h3;
      s_q.rise_pct   <= `DPS_PCT_RISE_0;
      s_q.fall_pct   <= `DPS_PCT_FALL_0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // all outputs come straight from the state register
  assign bus_rdata           = s_q.rdata;
  assign shed_threshold_code = ctl_code;
  assign thr_rise_pct        = s_q.rise_pct;
  assign thr_fall_pct        = s_q.fall_pct;
  assign active_phase_count  = s_q.active;
  assign phase_enable        = s_q.phase_en;
  assign avg_current_ref     = s_q.avg;

endmodule // dps_core

// ### verif/dps_sense_model.sv
// comparator model of the current limit sense network
`timescale 1ns/1ps
module dps_sense_model (
  input  wire logic       clk,
  input  wire logic [6:0] load_pct,
  input  wire logic [5:0] rise_pct,
  input  wire logic [5:0] fall_pct,
  output      logic       below = 1'h0,
  output      logic       above = 1'h0
);
  // levels in percent of full load; rise above fall gives hysteresis
  always @(posedge clk) begin
    below <= load_pct < 7'(fall_pct);
    above <= load_pct > 7'(rise_pct);
  end
endmodule // dps_sense_model

// ### verif/dps_core_assertions.sv
// port checks of the phase shedding controller
`timescale 1ns/1ps
module dps_core_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        sense_above_rise,
  input wire logic        voltage_step_transition,
  input wire logic        transient_boost_detect,
  input wire logic [15:0] phase_current_sum,
  input wire logic [1:0]  shed_threshold_code,
  input wire logic [5:0]  thr_rise_pct,
  input wire logic [5:0]  thr_fall_pct,
  input wire logic [2:0]  active_phase_count,
  input wire logic [3:0]  phase_enable,
  input wire logic [15:0] avg_current_ref
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [11:0] ev_cnt_q;
  // cycles since the last shedding reset event
  always_ff @(posedge clk) begin
    if (reset) ev_cnt_q <= 12'hFFF;
    else if (voltage_step_transition || transient_boost_detect) ev_cnt_q <= 12'h000;
    else if (ev_cnt_q != 12'hFFF) ev_cnt_q <= ev_cnt_q + 12'h001;
  end
  thr_pair_a: assert property (thr_rise_pct == thr_fall_pct + 6'h05) else $error("hysteresis gap");
  thr_code_a: assert property (!$past(reset) && $stable(shed_threshold_code)
    |-> thr_fall_pct == 6'(15 + 5 * shed_threshold_code)) else $error("threshold code");
  enable_map_a: assert property (phase_enable == 4'((1 << active_phase_count) - 1))
    else $error("phase enables");
  active_range_a: assert property (active_phase_count inside {[1:4]}) else $error("count range");
  event_restore_a: assert property ((voltage_step_transition || transient_boost_detect)
    |=> active_phase_count >= 3'h2) else $error("event restore");
  rearm_hold_a: assert property (ev_cnt_q < 12'd2400 |-> active_phase_count >= 3'h2)
    else $error("shed during rearm");
  above_restore_a: assert property (sense_above_rise [*5] |-> active_phase_count >= 3'h2)
    else $error("no restore");
  avg_ratio_a: assert property (!$past(reset) |-> avg_current_ref ==
    16'($past(phase_current_sum) / $past(active_phase_count))) else $error("average");
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0) else $error("read idle");
  cover property (active_phase_count == 3'h1);
  cover property (transient_boost_detect ##1 active_phase_count == 3'h4);
  cover property (bus_rd ##1 bus_rdata != 32'h0);
endmodule // dps_core_assertions
bind dps_core dps_core_assertions i_chk (.clk(clk), .reset(reset), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .sense_above_rise(sense_above_rise), .voltage_step_transition(voltage_step_transition),
  .transient_boost_detect(transient_boost_detect), .phase_current_sum(phase_current_sum),
  .shed_threshold_code(shed_threshold_code), .thr_rise_pct(thr_rise_pct), .thr_fall_pct(thr_fall_pct),
  .active_phase_count(active_phase_count), .phase_enable(phase_enable), .avg_current_ref(avg_current_ref));

// ### verif/dynamic_phase_shedding_test.sv
// self-checking bench of the phase shedding controller
`timescale 1ns/1ps
module dynamic_phase_shedding_test;
  logic        clk = 1'h0, reset = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0, pg = 1'h0, ssd = 1'h0;
  logic        g3 = 1'h0, g4 = 1'h0, below, above, step = 1'h0, boost = 1'h0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, v;
  logic [15:0] cur = 16'h0000;
  logic [1:0]  code;
  logic [5:0]  rise, fall;
  logic [2:0]  act;
  logic [3:0]  pen;
  logic [6:0]  load = 7'h00;
  int          errors = 0, check_count = 0, red;
  dps_core i_dut (.clk(clk), .reset(reset), .ce(1'h1), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .power_good(pg), .soft_start_done(ssd),
    .phase_three_grounded(g3), .phase_four_grounded(g4), .sense_below_fall(below), .sense_above_rise(above),
    .voltage_step_transition(step), .transient_boost_detect(boost), .phase_current_sum(cur),
    .shed_threshold_code(code), .thr_rise_pct(rise), .thr_fall_pct(fall), .active_phase_count(act),
    .phase_enable(pen), .avg_current_ref());
  dps_sense_model i_sense (.clk(clk), .load_pct(load), .rise_pct(rise), .fall_pct(fall), .below(below),
    .above(above));
  initial begin
    forever #2 clk = ~clk;
  end
  // random summed phase current every cycle
  always @(posedge clk) cur <= 16'($urandom);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'h1};
    @(posedge clk) bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) {bus_addr, bus_rd} <= {a, 1'h1};
    @(posedge clk) bus_rd <= 1'h0;
    #1 v = bus_rdata;
  endtask
  task automatic wait_act(input int e, input int n);
    for (int i = 0; i < n && act !== 3'(e); i++) @(posedge clk);
    chk(32'(act), 32'(e), "phase count");
    if (act !== 3'(e)) conclude();
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h61360dbd));
    // three strap settings (two, three and four phases), from reset
    for (int s = 0; s < 3; s++) begin
      {g3, g4} <= {s == 0, s < 2};
      reset <= 1'h1;
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      chk({code, rise, fall, pen}, {2'h0, 6'd20, 6'd15, 4'h3}, "reset values");
      repeat (10) @(posedge clk);
      rd(8'h04);
      chk(32'(v[6:4]), 32'(2 + s), "installed");
      wait_act(4 - g3 - g4, 2);
    end
    // enable refused before power good and soft-start
    wr(8'h00, 32'h1);
    rd(8'h04);
    chk({30'h0, v[13], v[9]}, 32'h2, "refusal");
    {pg, ssd} <= 2'h3;
    repeat (4) @(posedge clk);
    // every code and strategy: shed, event, rearm, restore
    for (int k = 0; k < 8; k++) begin
      red = (k % 2) + 1;
      load <= 7'(36 + $urandom % 60);
      wr(8'h00, 32'(k / 2 * 8 + k % 2 * 4 + 1));
      repeat (3) @(posedge clk);
      chk({code, rise}, {2'(k / 2), 6'(20 + 5 * (k / 2))}, "threshold");
      load <= 7'($urandom % (15 + 5 * (k / 2)));
      wait_act(red, 12);
      @(posedge clk) {step, boost} <= (k < 4) ? 2'h2 : 2'h1;
      @(posedge clk) {step, boost} <= 2'h0;
      @(posedge clk) chk(32'(act), 32'h4, "event");
      repeat (2300) @(posedge clk);
      chk(32'(act), 32'h4, "rearm hold");
      wait_act(red, 400);
      load <= 7'(36 + $urandom % 60);
      wait_act(4, 8);
    end
    // disabled: low load keeps all phases
    wr(8'h00, 32'h0);
    load <= 7'h01;
    repeat (10) @(posedge clk);
    chk(32'(act), 32'h4, "disabled");
    rd(8'h0C);
    chk(v, 32'h0, "unmapped read");
    conclude();
  end
endmodule // dynamic_phase_shedding_test
